// ===== hw/hss_defines.vh
// Constants for the hot-swap status register bank
`ifndef HSS_DEFINES_VH
`define HSS_DEFINES_VH

// Command codes of the status bytes
`define HSS_CMD_OUTPUT_SENSE_PIN_STATUS 8'h7A
`define HSS_CMD_IOUT_STATUS 8'h7B
`define HSS_CMD_INPUT_STATUS 8'h7C
`define HSS_CMD_VENDOR_STATUS 8'h80

// Reset value of every status byte
`define HSS_STATUS_RESET 8'h00

// Output-voltage status masks
`define HSS_OUTPUT_SENSE_PIN_OV_MASK 8'h40
`define HSS_OUTPUT_SENSE_PIN_UV_MASK 8'h20

// Output-current status masks
`define HSS_IOUT_OC_FAULT_MASK 8'h80
`define HSS_IOUT_OC_WARN_MASK 8'h20

// Input status masks; bits [3:0] stay zero
`define HSS_IN_OV_FAULT_MASK 8'h80
`define HSS_IN_OV_WARN_MASK 8'h40
`define HSS_IN_UV_WARN_MASK 8'h20
`define HSS_IN_UV_FAULT_MASK 8'h10

// Vendor status masks and shutdown-cause field
`define HSS_VS_SHORT_MASK 8'h80
`define HSS_VS_LOW_LIVE_MASK 8'h40
`define HSS_VS_HIGH_LIVE_MASK 8'h20
`define HSS_VS_LIMIT_MASK 8'h08
`define HSS_VS_WARN2_MASK 8'h01
`define HSS_VS_CAUSE_LSB 1
`define HSS_CAUSE_NONE 2'h0
`define HSS_CAUSE_OC 2'h1
`define HSS_CAUSE_UV 2'h2
`define HSS_CAUSE_OV 2'h3

// Serial link constants
`define HSS_BITS_PER_BYTE 4'h8
`define HSS_BIT_ONE 4'h1
`define HSS_BIT_ZERO 4'h0
`define HSS_SYNC_STAGES 2
`define HSS_NUM_SYNC 4
`define HSS_SYNC_SCL 0
`define HSS_SYNC_SDA 1
`define HSS_SYNC_LOW 2
`define HSS_SYNC_HIGH 3
`define HSS_SYNC_IDLE 4'h3

`endif

// ===== hw/hss_status_regs.v
// Hot-swap status byte bank answering byte reads on the management link
`timescale 1ns/1ps
`default_nettype none
`include "hss_defines.vh"

module hss_status_regs #(
  parameter [6:0] DEV_ADDR = 7'h2A,
  parameter HAS_OUTPUT_SENSE = 1
) (
  input wire clk,
  input wire rst_n,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o_q,
  output reg sda_oe_q,
  input wire low_pin_comparator_live,
  input wire high_pin_comparator_live,
  input wire output_sense_pin_ov_warn,
  input wire output_sense_pin_uv_warn,
  input wire iout_oc_warn,
  input wire vin_ov_warn,
  input wire vin_uv_warn,
  input wire oc_timeout_shutdown,
  input wire current_limiting_active,
  input wire pass_transistor_suspect_short,
  input wire [11:0] current_code,
  input wire [11:0] second_current_threshold,
  input wire second_threshold_polarity,
  input wire clear_faults,
  output reg [3:0] status_summary_q
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX = 5'h02;
  localparam [4:0] ST_ACK = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_HACK = 5'h10;
  localparam [`HSS_NUM_SYNC-1:0] SYNC_IDLE = `HSS_SYNC_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second; bus lines reset to idle high
  wire [`HSS_NUM_SYNC-1:0] raw_in;
  wire [`HSS_NUM_SYNC-1:0] sync_out;
  assign raw_in = {high_pin_comparator_live, low_pin_comparator_live, sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < `HSS_NUM_SYNC; gi = gi + 1) begin : g_sync
      reg [`HSS_SYNC_STAGES-1:0] stage_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_q <= {`HSS_SYNC_STAGES{SYNC_IDLE[gi]}};
        end else begin
          stage_q <= {stage_q[0], raw_in[gi]};
        end
      end
      assign sync_out[gi] = stage_q[`HSS_SYNC_STAGES-1];
    end
  endgenerate

  wire scl_s = sync_out[`HSS_SYNC_SCL];
  wire sda_s = sync_out[`HSS_SYNC_SDA];
  wire low_live = sync_out[`HSS_SYNC_LOW];
  wire high_live = sync_out[`HSS_SYNC_HIGH];

  reg scl_prev_q, sda_prev_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Latched status bits
  reg output_sense_pin_ov_q, output_sense_pin_uv_q, iout_fault_q, iout_warn_q;
  reg in_ov_fault_q, in_ov_warn_q, in_uv_warn_q, in_uv_fault_q;
  reg short_q, limit_q, warn2_q;
  reg [1:0] cause_q;
  reg [1:0] cause_d;

  wire warn2_hit = second_threshold_polarity ? (current_code > second_current_threshold) :
                                               (current_code < second_current_threshold);

  always @* begin
    cause_d = clear_faults ? `HSS_CAUSE_NONE : cause_q;
    if (cause_d == `HSS_CAUSE_NONE) begin
      if (high_live) begin
        cause_d = `HSS_CAUSE_OV;
      end else if (low_live) begin
        cause_d = `HSS_CAUSE_UV;
      end else if (oc_timeout_shutdown) begin
        cause_d = `HSS_CAUSE_OC;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_sense_pin_ov_q <= 1'b0;
      output_sense_pin_uv_q <= 1'b0;
      iout_fault_q <= 1'b0;
      iout_warn_q <= 1'b0;
      in_ov_fault_q <= 1'b0;
      in_ov_warn_q <= 1'b0;
      in_uv_warn_q <= 1'b0;
      in_uv_fault_q <= 1'b0;
      short_q <= 1'b0;
      limit_q <= 1'b0;
      warn2_q <= 1'b0;
      cause_q <= `HSS_CAUSE_NONE;
    end else begin
      output_sense_pin_ov_q <= (output_sense_pin_ov_q & ~clear_faults) | output_sense_pin_ov_warn;
      output_sense_pin_uv_q <= (output_sense_pin_uv_q & ~clear_faults) | output_sense_pin_uv_warn;
      iout_fault_q <= (iout_fault_q & ~clear_faults) | oc_timeout_shutdown;
      iout_warn_q <= (iout_warn_q & ~clear_faults) | iout_oc_warn;
      in_ov_fault_q <= (in_ov_fault_q & ~clear_faults) | high_live;
      in_uv_fault_q <= (in_uv_fault_q & ~clear_faults) | low_live;
      in_ov_warn_q <= (in_ov_warn_q & ~clear_faults) | vin_ov_warn;
      in_uv_warn_q <= (in_uv_warn_q & ~clear_faults) | vin_uv_warn;
      short_q <= (short_q & ~clear_faults) | pass_transistor_suspect_short;
      limit_q <= (limit_q & ~clear_faults) | current_limiting_active;
      warn2_q <= (warn2_q & ~clear_faults) | warn2_hit;
      cause_q <= cause_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly; unnamed bits stay zero
  wire [7:0] output_sense_pin_byte, iout_byte, input_byte, vendor_byte;

  // variants without the sense pin report nothing here
  assign output_sense_pin_byte = (HAS_OUTPUT_SENSE != 0) ?
                     ((`HSS_OUTPUT_SENSE_PIN_OV_MASK & {8{output_sense_pin_ov_q}}) |
                      (`HSS_OUTPUT_SENSE_PIN_UV_MASK & {8{output_sense_pin_uv_q}})) : `HSS_STATUS_RESET;
  assign iout_byte = (`HSS_IOUT_OC_FAULT_MASK & {8{iout_fault_q}}) |
                     (`HSS_IOUT_OC_WARN_MASK & {8{iout_warn_q}});
  assign input_byte = (`HSS_IN_OV_FAULT_MASK & {8{in_ov_fault_q}}) |
                      (`HSS_IN_OV_WARN_MASK & {8{in_ov_warn_q}}) |
                      (`HSS_IN_UV_WARN_MASK & {8{in_uv_warn_q}}) |
                      (`HSS_IN_UV_FAULT_MASK & {8{in_uv_fault_q}});
  assign vendor_byte = (`HSS_VS_SHORT_MASK & {8{short_q}}) |
                       (`HSS_VS_LOW_LIVE_MASK & {8{low_live}}) |
                       (`HSS_VS_HIGH_LIVE_MASK & {8{high_live}}) |
                       (`HSS_VS_LIMIT_MASK & {8{limit_q}}) |
                       ({6'h00, cause_q} << `HSS_VS_CAUSE_LSB) |
                       (`HSS_VS_WARN2_MASK & {8{warn2_q}});

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_summary_q <= 4'h0;
    end else begin
      status_summary_q <= {|output_sense_pin_byte, |iout_byte, |input_byte, |vendor_byte};
    end
  end

  function cmd_known;
    input [7:0] cmd;
    begin
      cmd_known = ((cmd == `HSS_CMD_OUTPUT_SENSE_PIN_STATUS) && (HAS_OUTPUT_SENSE != 0)) ||
                  (cmd == `HSS_CMD_IOUT_STATUS) || (cmd == `HSS_CMD_INPUT_STATUS) ||
                  (cmd == `HSS_CMD_VENDOR_STATUS);
    end
  endfunction

  function [7:0] sel_byte;
    input [7:0] cmd;
    input [7:0] b_output_sense_pin;
    input [7:0] b_iout;
    input [7:0] b_input;
    input [7:0] b_vendor;
    begin
      if (cmd == `HSS_CMD_OUTPUT_SENSE_PIN_STATUS) begin
        sel_byte = b_output_sense_pin;
      end else if (cmd == `HSS_CMD_IOUT_STATUS) begin
        sel_byte = b_iout;
      end else if (cmd == `HSS_CMD_INPUT_STATUS) begin
        sel_byte = b_input;
      end else if (cmd == `HSS_CMD_VENDOR_STATUS) begin
        sel_byte = b_vendor;
      end else begin
        sel_byte = `HSS_STATUS_RESET;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial byte-read engine
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg [7:0] tx_q;
  reg [7:0] tx_d;
  reg [7:0] cmd_q;
  reg [7:0] cmd_d;
  reg cmd_ok_q, cmd_seen_q, first_q, rd_q;
  reg cmd_ok_d, cmd_seen_d, first_d, rd_d;
  reg oe_d, ack_v;
  wire [7:0] cur_byte = sel_byte(cmd_q, output_sense_pin_byte, iout_byte, input_byte, vendor_byte);

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    cmd_ok_d = cmd_ok_q;
    cmd_seen_d = cmd_seen_q;
    first_d = first_q;
    rd_d = rd_q;
    oe_d = sda_oe_q;
    ack_v = 1'b0;
    if (stop_det) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start_det) begin
      // Repeated start keeps the command for the read that follows
      state_d = ST_RX;
      cnt_d = `HSS_BIT_ZERO;
      first_d = 1'b1;
      cmd_seen_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + `HSS_BIT_ONE;
          end else if (scl_fall && (cnt_q == `HSS_BITS_PER_BYTE)) begin
            cnt_d = `HSS_BIT_ZERO;
            if (first_q) begin
              first_d = 1'b0;
              rd_d = shift_q[0];
              // read only after a command byte
              ack_v = (shift_q[7:1] == DEV_ADDR) && (!shift_q[0] || cmd_ok_q);
              tx_d = cur_byte;
            end else if (!rd_q && !cmd_seen_q) begin
              cmd_d = shift_q;
              cmd_seen_d = 1'b1;
              cmd_ok_d = cmd_known(shift_q);
              ack_v = cmd_known(shift_q);
            end
            oe_d = ack_v;
            state_d = ack_v ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = `HSS_BIT_ONE;
              state_d = ST_TX;
            end else begin
              oe_d = 1'b0;
              cnt_d = `HSS_BIT_ZERO;
              state_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == `HSS_BITS_PER_BYTE) begin
              oe_d = 1'b0;
              state_d = ST_HACK;
            end else begin
              oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + `HSS_BIT_ONE;
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            // Host ack asks for the same byte again
            tx_d = cur_byte;
            state_d = sda_s ? ST_IDLE : ST_ACK;
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= `HSS_BIT_ZERO;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      cmd_ok_q <= 1'b0;
      cmd_seen_q <= 1'b0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      cmd_ok_q <= cmd_ok_d;
      cmd_seen_q <= cmd_seen_d;
      first_q <= first_d;
      rd_q <= rd_d;
      sda_oe_q <= oe_d;
      // Open drain: only ever pulls low
      sda_o_q <= 1'b0;
    end
  end

endmodule // hss_status_regs
`default_nettype wire

// ===== sim/hss_host_model.sv
// Management-bus host model issuing status byte reads
`timescale 1ns/1ps
`default_nettype none
module hss_host_model (
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Data moves late in the low phase so the device's drive changes settle first
  task automatic slot(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #120 sda_rel = v[i];
      #40 scl = 1'b1;
      #20 r[i] = sda;
      #20 scl = 1'b0;
    end
  endtask
  task automatic byte_read(input logic [6:0] a, input logic [7:0] c,
      output logic [7:0] d, output logic [2:0] ack);
    logic [8:0] r;
    sda_rel = 1'b0;
    #100 scl = 1'b0;
    slot({a, 2'b01}, r);
    ack[2] = ~r[0];
    slot({c, 1'b1}, r);
    ack[1] = ~r[0];
    #120 sda_rel = 1'b1;
    #40 scl = 1'b1;
    #60 sda_rel = 1'b0;
    #60 scl = 1'b0;
    slot({a, 2'b11}, r);
    ack[0] = ~r[0];
    slot(9'h1FF, r);
    d = r[8:1];
    #120 sda_rel = 1'b0;
    #40 scl = 1'b1;
    #60 sda_rel = 1'b1;
    #100;
  endtask
endmodule // hss_host_model
`default_nettype wire

// ===== sim/hss_status_checker.sv
// Port-level assertions for the status byte bank
`timescale 1ns/1ps
`default_nettype none
module hss_status_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_oe_q,
  input wire logic low_pin_comparator_live,
  input wire logic high_pin_comparator_live,
  input wire logic output_sense_pin_ov_warn,
  input wire logic output_sense_pin_uv_warn,
  input wire logic iout_oc_warn,
  input wire logic vin_ov_warn,
  input wire logic vin_uv_warn,
  input wire logic oc_timeout_shutdown,
  input wire logic current_limiting_active,
  input wire logic pass_transistor_suspect_short,
  input wire logic [11:0] current_code,
  input wire logic [11:0] second_current_threshold,
  input wire logic second_threshold_polarity,
  input wire logic clear_faults,
  input wire logic [3:0] status_summary_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  output_sense_pin_sum_a: assert property ((output_sense_pin_ov_warn || output_sense_pin_uv_warn) |-> ##2 status_summary_q[3])
    else $error("output_sense_pin summary not set");
  iout_sum_a: assert property ((oc_timeout_shutdown || iout_oc_warn) |-> ##2 status_summary_q[2])
    else $error("iout summary not set");
  input_sum_a: assert property ((vin_ov_warn || vin_uv_warn) |-> ##2 status_summary_q[1])
    else $error("input summary not set");
  vendor_sum_a: assert property ((current_limiting_active || pass_transistor_suspect_short)
    |-> ##2 status_summary_q[0])
    else $error("vendor summary not set");
  warn2_sum_a: assert property ((second_threshold_polarity ? current_code > second_current_threshold
    : current_code < second_current_threshold) |-> ##2 status_summary_q[0])
    else $error("second warning not seen");
  // Pin path goes through the synchroniser, hence the longer lead
  low_pin_a: assert property (low_pin_comparator_live [*4] |=> status_summary_q[1:0] == 2'h3)
    else $error("low pin trip not seen");
  high_pin_a: assert property (high_pin_comparator_live [*4] |=> status_summary_q[1:0] == 2'h3)
    else $error("high pin trip not seen");
  latch_hold_a: assert property ((status_summary_q[3] && !clear_faults && !$past(clear_faults))
    |=> status_summary_q[3])
    else $error("latched bit lost");
  fault_clear_a: assert property ((clear_faults && !output_sense_pin_ov_warn && !output_sense_pin_uv_warn)
    |-> ##2 !status_summary_q[3])
    else $error("clear did not drop bits");
  drive_edge_a: assert property ($changed(sda_oe_q) |-> !scl_i)
    else $error("data drive moved while clock high");
endmodule // hss_status_checker
bind hss_status_regs hss_status_checker chk (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
  .sda_oe_q(sda_oe_q), .low_pin_comparator_live(low_pin_comparator_live),
  .high_pin_comparator_live(high_pin_comparator_live), .output_sense_pin_ov_warn(output_sense_pin_ov_warn),
  .output_sense_pin_uv_warn(output_sense_pin_uv_warn), .iout_oc_warn(iout_oc_warn), .vin_ov_warn(vin_ov_warn),
  .vin_uv_warn(vin_uv_warn), .oc_timeout_shutdown(oc_timeout_shutdown),
  .current_limiting_active(current_limiting_active),
  .pass_transistor_suspect_short(pass_transistor_suspect_short), .current_code(current_code),
  .second_current_threshold(second_current_threshold),
  .second_threshold_polarity(second_threshold_polarity), .clear_faults(clear_faults),
  .status_summary_q(status_summary_q));
`default_nettype wire

// ===== sim/hss_status_regs_bench.sv
// Self-checking bench for the status byte bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module hss_status_regs_bench;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [6:0] ADDR2 = 7'h2B;
  logic clk, rst_n, lo, hi, pol, scl, sda_rel, sda_oe, sda_oe2, sda_o, sda;
  logic [8:0] ev;
  logic [11:0] code, thr;
  logic [3:0] summ;
  int miscompares, n_tests, cyc;
  assign sda = sda_rel & ~sda_oe & ~sda_oe2;
  hss_status_regs #(.DEV_ADDR(ADDR), .HAS_OUTPUT_SENSE(1)) uut (.clk(clk), .rst_n(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o_q(sda_o), .sda_oe_q(sda_oe), .low_pin_comparator_live(lo),
    .high_pin_comparator_live(hi), .output_sense_pin_ov_warn(ev[0]), .output_sense_pin_uv_warn(ev[1]),
    .iout_oc_warn(ev[2]), .vin_ov_warn(ev[3]), .vin_uv_warn(ev[4]),
    .oc_timeout_shutdown(ev[5]), .current_limiting_active(ev[6]),
    .pass_transistor_suspect_short(ev[7]), .current_code(code),
    .second_current_threshold(thr), .second_threshold_polarity(pol), .clear_faults(ev[8]),
    .status_summary_q(summ));
  // Variant without the output sense pin, on its own address and with quiet monitors
  hss_status_regs #(.DEV_ADDR(ADDR2), .HAS_OUTPUT_SENSE(0)) uut2 (.clk(clk), .rst_n(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o_q(), .sda_oe_q(sda_oe2), .low_pin_comparator_live(1'b0),
    .high_pin_comparator_live(1'b0), .output_sense_pin_ov_warn(1'b0), .output_sense_pin_uv_warn(1'b0),
    .iout_oc_warn(1'b0), .vin_ov_warn(1'b0), .vin_uv_warn(1'b0), .oc_timeout_shutdown(1'b0),
    .current_limiting_active(1'b0), .pass_transistor_suspect_short(1'b0),
    .current_code(12'h000), .second_current_threshold(12'h000),
    .second_threshold_polarity(1'b0), .clear_faults(1'b0), .status_summary_q());
  hss_host_model host (.sda(sda), .scl(scl), .sda_rel(sda_rel));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // About 28 reads of some 320 cycles each; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic pulse(input logic [8:0] m);
    @(negedge clk) ev = m;
    @(negedge clk) ev = 9'h000;
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    logic [2:0] a;
    host.byte_read(ADDR, c, d, a);
    `CHK(a, 3'b111)
    `CHK(d, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h7A, 8'h00);
    rd(8'h7B, 8'h00);
    rd(8'h7C, 8'h00);
    rd(8'h80, 8'h00);
    `CHK(summ, 4'h0)
    `CHK(sda_o, 1'b0)
  endtask
  task automatic t_output_sense_pin;
    pulse(9'h001);
    rd(8'h7A, 8'h40);
    `CHK(summ, 4'h8)
    pulse(9'h002);
    rd(8'h7A, 8'h60);
    pulse(9'h100);
    rd(8'h7A, 8'h00);
  endtask
  task automatic t_iout;
    pulse(9'h040);
    rd(8'h7B, 8'h00);
    rd(8'h80, 8'h08);
    pulse(9'h020);
    rd(8'h7B, 8'h80);
    rd(8'h80, 8'h0A);
    pulse(9'h004);
    rd(8'h7B, 8'hA0);
    pulse(9'h180);
    rd(8'h80, 8'h80);
    pulse(9'h100);
  endtask
  task automatic t_input;
    pulse(9'h018);
    rd(8'h7C, 8'h60);
    `CHK(summ, 4'h2)
    // Mid-run reset must bring every byte back to zero
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK(summ, 4'h0)
    repeat (4) @(negedge clk);
    rd(8'h7C, 8'h00);
    pulse(9'h100);
  endtask
  task automatic t_pins;
    @(negedge clk) lo = 1'b1;
    rd(8'h7C, 8'h10);
    rd(8'h80, 8'h44);
    @(negedge clk) lo = 1'b0;
    rd(8'h80, 8'h04);
    pulse(9'h100);
    @(negedge clk) hi = 1'b1;
    rd(8'h7C, 8'h80);
    rd(8'h80, 8'h26);
    @(negedge clk) hi = 1'b0;
    // Let the synchroniser drain, or the clear loses to a still-live trip
    repeat (3) @(negedge clk);
    pulse(9'h100);
    rd(8'h7C, 8'h00);
  endtask
  task automatic t_warn2;
    @(negedge clk) {code, thr} = {12'h101, 12'h100};
    rd(8'h80, 8'h01);
    pulse(9'h100);
    @(negedge clk) code = 12'h100;
    pulse(9'h100);
    rd(8'h80, 8'h00);
    @(negedge clk) {pol, code} = {1'b0, 12'h0FF};
    rd(8'h80, 8'h01);
    @(negedge clk) {pol, code, thr} = {1'b1, 12'h000, 12'hFFF};
    pulse(9'h100);
  endtask
  task automatic t_refuse;
    logic [7:0] d;
    logic [2:0] a;
    host.byte_read(7'h2C, 8'h7A, d, a);
    `CHK({a, d}, 11'h0FF)
    host.byte_read(ADDR, 8'h7D, d, a);
    `CHK({a, d}, 11'h4FF)
    host.byte_read(ADDR2, 8'h7A, d, a);
    `CHK({a, d}, 11'h4FF)
    host.byte_read(ADDR2, 8'h7B, d, a);
    `CHK({a, d}, 11'h700)
  endtask
  initial begin
    {rst_n, lo, hi, pol, ev, code, thr} = {4'h1, 9'h000, 12'h000, 12'hFFF};
    miscompares = 0;
    n_tests = 0;
    cyc = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_output_sense_pin();
    t_iout();
    t_input();
    t_pins();
    t_warn2();
    t_refuse();
    stop_test();
  end
endmodule // hss_status_regs_bench
`default_nettype wire
